// ===== logic/dir_identity_record.sv
// device identity record: six read-only identity bytes on the byte bus
// assumes a synchronous byte bus and a separate flash programming path
//
// Overview of operation
// RQ1: six identity bytes; byte 0 stands apart, bytes 1 to 5 are consecutive.
// RQ2: byte 0 is entirely the firmware descriptor, no configuration or serial bits.
// RQ3: config bits 7..5 give silicon revision, valid from 3 to 7.
// RQ4: config bits 4 and 0 encode pressure range 500, 900 or 1500 kPa.
// RQ5: config bits 3..2 give accelerometer fit: none, X, Z or both.
// RQ6: config bit 1 selects standard or extended accelerometer calibration span.
// RQ7: serial bits 13..0 give device index within the assembly lot.
// RQ8: lot number low 13 bits at serial 26..14, upper 2 at 29..28.
// RQ9: serial bit 30 names the subcontractor, bit 31 the supplier.
// RQ10: low 28 serial bits form the unique sequential serial number.
// RQ11: upper nibble of byte 5 is vendor type, defaulted when left unspecified.
// RQ12: whoever erases flash saves the six bytes and restores them afterwards.
// RQ13: bytes are read-only by index; bus writes never change them.
`timescale 1ns/10ps
`default_nettype none
`include "dir_defines.svh"

module dir_identity_record
   import dir_pkg::*;
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   // byte bus
   input wire logic [15:0] bus_addr_in,
   input wire logic bus_rd_in,
   input wire logic bus_wr_in,
   output logic [7:0] bus_rdata_out,
   output logic bus_hit_out,
   output logic bus_wr_ignored_out,
   // flash programming path
   input wire logic prog_we_in,
   input wire logic [2:0] prog_index_in,
   input wire logic [7:0] prog_data_in,
   input wire logic prog_vendor_set_in,
   // decoded identity
   output logic [7:0] firmware_descriptor_out,
   output logic [2:0] silicon_revision_out,
   output logic revision_valid_out,
   output dir_pressure_range_high_e pressure_range_high_range_out,
   output dir_acc_e accel_fit_out,
   output logic accel_extended_cal_out,
   output logic [13:0] lot_index_out,
   output logic [14:0] lot_number_out,
   output logic subcon_out,
   output logic supplier_out,
   output logic [27:0] serial_number_out,
   output logic [3:0] vendor_type_out
);

   // non-volatile cells: deliberately not cleared by reset, contents survive it
   logic [7:0] id_mem [0:`DIR_NUM_BYTES-1];

   wire logic [5:0] addr_match;
   wire logic rd_hit;
   wire logic [2:0] rd_index;
   wire logic prog_ok;
   wire logic [7:0] prog_byte;
   wire logic [31:0] serial_word;
   wire logic [2:0] dec_rev;
   wire logic dec_rev_ok;
   dir_pressure_range_high_e dec_pressure_range_high;
   dir_acc_e dec_acc;
   wire logic dec_acc_cal;
   wire logic [13:0] dec_lot_index;
   wire logic [14:0] dec_lot;
   wire logic dec_subcon;
   wire logic dec_supplier;
   wire logic [27:0] dec_serial;
   wire logic [3:0] dec_vendor;

   logic [7:0] rdata_q;
   logic hit_q;
   logic wr_ign_q;
   logic [7:0] fw_q;
   logic [2:0] rev_q;
   logic rev_ok_q;
   dir_pressure_range_high_e pressure_range_high_q;
   dir_acc_e acc_q;
   logic acc_cal_q;
   logic [13:0] lot_index_q;
   logic [14:0] lot_q;
   logic subcon_q;
   logic supplier_q;
   logic [27:0] serial_q;
   logic [3:0] vendor_q;

   // byte 0 sits apart; bytes 1..5 follow the config address
   assign addr_match[0] = (bus_addr_in == `DIR_ADDR_FW_DESC); // RQ1
   genvar gi;
   generate
      for (gi = 1; gi < `DIR_NUM_BYTES; gi = gi + 1)
      begin : g_match
         assign addr_match[gi] = (bus_addr_in == (`DIR_ADDR_CONFIG + 16'(gi - 1))); // RQ1
      end
   endgenerate

   assign rd_hit = |addr_match;
   assign rd_index = addr_match[5] ? 3'h5 : addr_match[4] ? 3'h4 : addr_match[3] ? 3'h3 :
                     addr_match[2] ? 3'h2 : addr_match[1] ? 3'h1 : 3'h0;

   // the bus has no path into the cells; only the programming path loads them
   assign prog_ok = prog_we_in && (prog_index_in < 3'(`DIR_NUM_BYTES)); // RQ13
   // an unspecified vendor nibble is replaced by the defined default
   assign prog_byte = (prog_index_in == `DIR_IDX_SERIAL_VEND && !prog_vendor_set_in)
                    ? {`DIR_VENDOR_DEFAULT, prog_data_in[3:0]} : prog_data_in; // RQ11

   // byte 0 takes no part in the serial word or configuration
   assign serial_word = {id_mem[5], id_mem[4], id_mem[3], id_mem[2]}; // RQ2

   dir_field_decode u_decode (
      .config_in(id_mem[`DIR_IDX_CONFIG]),
      .serial_word_in(serial_word),
      .silicon_revision_out(dec_rev),
      .revision_valid_out(dec_rev_ok),
      .pressure_range_high_range_out(dec_pressure_range_high),
      .accel_fit_out(dec_acc),
      .accel_extended_cal_out(dec_acc_cal),
      .lot_index_out(dec_lot_index),
      .lot_number_out(dec_lot),
      .subcon_out(dec_subcon),
      .supplier_out(dec_supplier),
      .serial_number_out(dec_serial),
      .vendor_type_out(dec_vendor)
   );

   always_ff @(posedge clock_in)
   begin
      if (clk_en_in && prog_ok)
      begin
         id_mem[prog_index_in] <= prog_byte; // RQ11
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in && clk_en_in)
      begin
         rdata_q <= 8'h00;
         hit_q <= 1'b0;
         wr_ign_q <= 1'b0;
      end
      else if (clk_en_in)
      begin
         rdata_q <= (bus_rd_in && rd_hit) ? id_mem[rd_index] : 8'h00; // RQ13
         hit_q <= bus_rd_in && rd_hit;
         wr_ign_q <= bus_wr_in && rd_hit; // RQ13
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in && clk_en_in)
      begin
         fw_q <= 8'h00;
         rev_q <= 3'h0;
         rev_ok_q <= 1'b0;
         pressure_range_high_q <= DIR_PRESSURE_RANGE_HIGH_500;
         acc_q <= DIR_ACC_NONE;
         acc_cal_q <= 1'b0;
      end
      else if (clk_en_in)
      begin
         fw_q <= id_mem[`DIR_IDX_FW_DESC]; // RQ2
         rev_q <= dec_rev; // RQ3
         rev_ok_q <= dec_rev_ok; // RQ3
         pressure_range_high_q <= dec_pressure_range_high; // RQ4
         acc_q <= dec_acc; // RQ5
         acc_cal_q <= dec_acc_cal; // RQ6
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in && clk_en_in)
      begin
         lot_index_q <= 14'h0000;
         lot_q <= 15'h0000;
         subcon_q <= 1'b0;
         supplier_q <= 1'b0;
         serial_q <= 28'h0000000;
         vendor_q <= 4'h0;
      end
      else if (clk_en_in)
      begin
         lot_index_q <= dec_lot_index; // RQ7
         lot_q <= dec_lot; // RQ8
         subcon_q <= dec_subcon; // RQ9
         supplier_q <= dec_supplier; // RQ9
         serial_q <= dec_serial; // RQ10
         vendor_q <= dec_vendor; // RQ11
      end
   end

   assign bus_rdata_out = rdata_q;
   assign bus_hit_out = hit_q;
   assign bus_wr_ignored_out = wr_ign_q;
   assign firmware_descriptor_out = fw_q;
   assign silicon_revision_out = rev_q;
   assign revision_valid_out = rev_ok_q;
   assign pressure_range_high_range_out = pressure_range_high_q;
   assign accel_fit_out = acc_q;
   assign accel_extended_cal_out = acc_cal_q;
   assign lot_index_out = lot_index_q;
   assign lot_number_out = lot_q;
   assign subcon_out = subcon_q;
   assign supplier_out = supplier_q;
   assign serial_number_out = serial_q;
   assign vendor_type_out = vendor_q;

endmodule // dir_identity_record
`default_nettype wire

// ===== logic/dir_defines.svh
// identity record constants: byte addresses, field positions, defaults
// assumes inclusion by the identity record package and modules only
`ifndef DIR_DEFINES_SVH
`define DIR_DEFINES_SVH

// byte addresses of the six identity bytes
`define DIR_ADDR_FW_DESC     16'hE0A0
`define DIR_ADDR_CONFIG      16'hFDF2
`define DIR_ADDR_SERIAL0     16'hFDF3
`define DIR_ADDR_SERIAL1     16'hFDF4
`define DIR_ADDR_SERIAL2     16'hFDF5
`define DIR_ADDR_SERIAL_VEND 16'hFDF6

// identity byte indices
`define DIR_IDX_FW_DESC      3'h0
`define DIR_IDX_CONFIG       3'h1
`define DIR_IDX_SERIAL0      3'h2
`define DIR_IDX_SERIAL_VEND  3'h5
`define DIR_NUM_BYTES        6

// config byte fields
`define DIR_CFG_REV_HI       7
`define DIR_CFG_REV_LO       5
`define DIR_CFG_PRESSURE_RANGE_HIGH_HI     4
`define DIR_CFG_ACC_HI       3
`define DIR_CFG_ACC_LO       2
`define DIR_CFG_ACC_CAL      1
`define DIR_CFG_PRESSURE_RANGE_HIGH_LO     0
`define DIR_REV_MIN          3'h3
`define DIR_REV_MAX          3'h7

// serial word fields
`define DIR_SER_INDEX_HI     13
`define DIR_SER_LOT_LO_HI    26
`define DIR_SER_LOT_LO_LO    14
`define DIR_SER_LOT_UP_HI    29
`define DIR_SER_LOT_UP_LO    28
`define DIR_SER_SUBCON       30
`define DIR_SER_SUPPLIER     31
`define DIR_SER_NUM_HI       27

// vendor nibble used when programming leaves it unspecified; value is arbitrary
`define DIR_VENDOR_DEFAULT   4'hA

`endif

// ===== logic/dir_pkg.sv
// identity record types: decoded configuration enumerations
// assumes nothing beyond the shared defines header
package dir_pkg;

   typedef enum logic [1:0] {
      DIR_PRESSURE_RANGE_HIGH_500  = 2'b00,
      DIR_PRESSURE_RANGE_HIGH_900  = 2'b01,
      DIR_PRESSURE_RANGE_HIGH_1500 = 2'b10,
      DIR_PRESSURE_RANGE_HIGH_BAD  = 2'b11
   } dir_pressure_range_high_e;

   typedef enum logic [1:0] {
      DIR_ACC_NONE = 2'b00,
      DIR_ACC_X    = 2'b01,
      DIR_ACC_Z    = 2'b10,
      DIR_ACC_XZ   = 2'b11
   } dir_acc_e;

endpackage

// ===== logic/dir_field_decode.sv
// combinational decode of the configuration byte and the serial word
// assumes its inputs are stable stored identity bytes
`timescale 1ns/10ps
`default_nettype none
`include "dir_defines.svh"

module dir_field_decode
   import dir_pkg::*;
(
   input wire logic [7:0] config_in,
   input wire logic [31:0] serial_word_in,
   output logic [2:0] silicon_revision_out,
   output logic revision_valid_out,
   output dir_pressure_range_high_e pressure_range_high_range_out,
   output dir_acc_e accel_fit_out,
   output logic accel_extended_cal_out,
   output logic [13:0] lot_index_out,
   output logic [14:0] lot_number_out,
   output logic subcon_out,
   output logic supplier_out,
   output logic [27:0] serial_number_out,
   output logic [3:0] vendor_type_out
);

   wire logic pressure_range_high;
   wire logic pressure_range_low;

   assign silicon_revision_out = config_in[`DIR_CFG_REV_HI:`DIR_CFG_REV_LO]; // RQ3
   assign revision_valid_out = (silicon_revision_out >= `DIR_REV_MIN) &&
                               (silicon_revision_out <= `DIR_REV_MAX); // RQ3
   assign pressure_range_high = config_in[`DIR_CFG_PRESSURE_RANGE_HIGH_HI];
   assign pressure_range_low = config_in[`DIR_CFG_PRESSURE_RANGE_HIGH_LO];
   // low bit set without high bit is not a calibrated range
   assign pressure_range_high_range_out = !pressure_range_low ? (pressure_range_high ? DIR_PRESSURE_RANGE_HIGH_900 : DIR_PRESSURE_RANGE_HIGH_500)
                          : (pressure_range_high ? DIR_PRESSURE_RANGE_HIGH_1500 : DIR_PRESSURE_RANGE_HIGH_BAD); // RQ4
   assign accel_fit_out = dir_acc_e'(config_in[`DIR_CFG_ACC_HI:`DIR_CFG_ACC_LO]); // RQ5
   assign accel_extended_cal_out = config_in[`DIR_CFG_ACC_CAL]; // RQ6

   assign lot_index_out = serial_word_in[`DIR_SER_INDEX_HI:0]; // RQ7
   assign lot_number_out = {serial_word_in[`DIR_SER_LOT_UP_HI:`DIR_SER_LOT_UP_LO],
                            serial_word_in[`DIR_SER_LOT_LO_HI:`DIR_SER_LOT_LO_LO]}; // RQ8
   assign subcon_out = serial_word_in[`DIR_SER_SUBCON]; // RQ9
   assign supplier_out = serial_word_in[`DIR_SER_SUPPLIER]; // RQ9
   assign serial_number_out = serial_word_in[`DIR_SER_NUM_HI:0]; // RQ10
   assign vendor_type_out = serial_word_in[31:28]; // RQ11

endmodule // dir_field_decode
`default_nettype wire

// ===== sim/dir_identity_record_assertions.sv
// checker for the identity record: bus answers and decoded field relations
// assumes binding to dir_identity_record and sight of its ports only
`timescale 1ns/10ps
`default_nettype none
`include "dir_defines.svh"

module dir_identity_record_assertions
   import dir_pkg::*;
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic [15:0] bus_addr_in,
   input wire logic bus_rd_in,
   input wire logic bus_wr_in,
   input wire logic [7:0] bus_rdata_out,
   input wire logic bus_hit_out,
   input wire logic bus_wr_ignored_out,
   input wire logic prog_we_in,
   input wire logic [7:0] firmware_descriptor_out,
   input wire logic [2:0] silicon_revision_out,
   input wire logic revision_valid_out,
   input wire dir_pressure_range_high_e pressure_range_high_range_out,
   input wire dir_acc_e accel_fit_out,
   input wire logic accel_extended_cal_out,
   input wire logic [13:0] lot_index_out,
   input wire logic [14:0] lot_number_out,
   input wire logic subcon_out,
   input wire logic supplier_out,
   input wire logic [27:0] serial_number_out,
   input wire logic [3:0] vendor_type_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   wire addr_hit;
   // byte 0 sits apart, bytes 1 to 5 form one contiguous run
   assign addr_hit = (bus_addr_in == `DIR_ADDR_FW_DESC) ||
                     (bus_addr_in >= `DIR_ADDR_CONFIG && bus_addr_in <= `DIR_ADDR_SERIAL_VEND);
   // case equality so unwritten cells, unknown on both sides, do not fire
   a_read_hit: assert property ((clk_en_in && bus_rd_in && addr_hit) ##1 clk_en_in |-> bus_hit_out)
      else $error("read of an identity byte gave no hit");
   a_read_miss: assert property ((clk_en_in && bus_rd_in && !addr_hit) ##1 clk_en_in
      |-> !bus_hit_out && bus_rdata_out == 8'h00)
      else $error("unmapped read answered");
   a_write_flag: assert property ((clk_en_in && bus_wr_in && addr_hit) ##1 clk_en_in |-> bus_wr_ignored_out)
      else $error("write to identity byte not flagged");
   a_write_keeps: assert property ((clk_en_in && bus_wr_in && addr_hit && !prog_we_in) ##1 clk_en_in
      |=> $stable(serial_number_out) && $stable(firmware_descriptor_out))
      else $error("bus write changed contents");
   a_fw_byte: assert property (bus_hit_out && $past(clk_en_in) && $past(bus_addr_in) == `DIR_ADDR_FW_DESC
      |-> bus_rdata_out === firmware_descriptor_out)
      else $error("firmware descriptor differs from byte 0");
   a_cfg_decode: assert property (bus_hit_out && $past(clk_en_in) && $past(bus_addr_in) == `DIR_ADDR_CONFIG
      |-> {silicon_revision_out, pressure_range_high_range_out, accel_fit_out, accel_extended_cal_out} ===
      {bus_rdata_out[7:5], bus_rdata_out[0], bus_rdata_out[4] ^ bus_rdata_out[0], bus_rdata_out[3:1]})
      else $error("config decode mismatch");
   a_rev_valid: assert property (revision_valid_out === (silicon_revision_out >= `DIR_REV_MIN))
      else $error("revision valid flag wrong");
   a_lot_index: assert property (lot_index_out === serial_number_out[13:0])
      else $error("lot index not serial low bits");
   a_lot_split: assert property (lot_number_out === {vendor_type_out[1:0], serial_number_out[26:14]})
      else $error("lot number split wrong");
   a_top_bits: assert property ({supplier_out, subcon_out} === vendor_type_out[3:2])
      else $error("supplier or subcontractor bit wrong");
endmodule // dir_identity_record_assertions

bind dir_identity_record dir_identity_record_assertions dir_identity_record_assertions_inst (
   .clock_in, .sys_rst_in, .clk_en_in, .bus_addr_in, .bus_rd_in, .bus_wr_in, .bus_rdata_out, .bus_hit_out,
   .bus_wr_ignored_out, .prog_we_in, .firmware_descriptor_out, .silicon_revision_out, .revision_valid_out,
   .pressure_range_high_range_out, .accel_fit_out, .accel_extended_cal_out, .lot_index_out, .lot_number_out, .subcon_out,
   .supplier_out, .serial_number_out, .vendor_type_out);
`default_nettype wire

// ===== sim/dir_identity_record_bench.sv
// self-checking bench for the identity record
// assumes one 200 MHz clock and the checker bound beside the design
`timescale 1ns/10ps
`default_nettype none
`include "dir_defines.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end

module dir_identity_record_bench import dir_pkg::*;;
   logic clock_in = 1'b0, sys_rst_in = 1'b1, clk_en_in = 1'b1, bus_rd_in = 1'b0, bus_wr_in = 1'b0;
   logic [15:0] bus_addr_in = 16'h0000;
   logic prog_we_in = 1'b0, prog_vendor_set_in = 1'b0;
   logic [2:0] prog_index_in = 3'h0;
   logic [7:0] prog_data_in = 8'h00, bus_rdata_out, firmware_descriptor_out;
   logic bus_hit_out, bus_wr_ignored_out, revision_valid_out, accel_extended_cal_out, subcon_out, supplier_out;
   logic [2:0] silicon_revision_out;
   dir_pressure_range_high_e pressure_range_high_range_out;
   dir_acc_e accel_fit_out;
   logic [13:0] lot_index_out;
   logic [14:0] lot_number_out;
   logic [27:0] serial_number_out;
   logic [3:0] vendor_type_out;
   logic [31:0] ser;
   int failures = 0, check_count = 0, cycles = 0;
   logic [7:0] vals [6] = '{8'h3C, 8'h60, 8'h5A, 8'hC3, 8'h96, 8'hE7};
   logic [15:0] addrs [6] = '{16'hE0A0, 16'hFDF2, 16'hFDF3, 16'hFDF4, 16'hFDF5, 16'hFDF6};
   logic [15:0] misses [3] = '{16'hE0A1, 16'hFDF1, 16'hFDF7};
   // config byte, then {revision, valid, pressure code, accel fit, extended cal}
   logic [16:0] cfg_rows [5] = '{{8'h60, 9'h0E0}, {8'h5C, 9'h08E}, {8'hF3, 9'h1F1}, {8'h85, 9'h13A},
                                 {8'hA8, 9'h164}};

   dir_identity_record dir_identity_record_inst (.clock_in, .sys_rst_in, .clk_en_in, .bus_addr_in, .bus_rd_in,
      .bus_wr_in, .bus_rdata_out, .bus_hit_out, .bus_wr_ignored_out, .prog_we_in, .prog_index_in, .prog_data_in,
      .prog_vendor_set_in, .firmware_descriptor_out, .silicon_revision_out, .revision_valid_out,
      .pressure_range_high_range_out, .accel_fit_out, .accel_extended_cal_out, .lot_index_out, .lot_number_out, .subcon_out,
      .supplier_out, .serial_number_out, .vendor_type_out);

   always #2.5 clock_in = ~clock_in;

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge clock_in)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic tick();
      @(posedge clock_in);
      #1;
   endtask

   // second tick lets the decoded outputs catch up with the cell
   task automatic prog(input logic [2:0] idx, input logic [7:0] d, input logic vs);
      prog_we_in = 1'b1;
      prog_index_in = idx;
      prog_data_in = d;
      prog_vendor_set_in = vs;
      tick();
      prog_we_in = 1'b0;
      tick();
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h);
      bus_addr_in = a;
      bus_rd_in = 1'b1;
      tick();
      bus_rd_in = 1'b0;
      `CHK(bus_hit_out, h)
      `CHK(bus_rdata_out, e)
      // let an edge pass so the next call never raises the strobe it just lowered
      tick();
   endtask

   initial
   begin
      repeat (4) @(posedge clock_in);
      #1;
      `CHK(bus_hit_out, 1'b0)
      sys_rst_in = 1'b0;
      tick();
      for (int i = 0; i < 6; i++) prog(3'(i), vals[i], 1'b1);
      for (int i = 0; i < 6; i++) rd(addrs[i], vals[i], 1'b1);
      for (int i = 0; i < 3; i++) rd(misses[i], 8'h00, 1'b0);
      `CHK(firmware_descriptor_out, vals[0])
      ser = {vals[5], vals[4], vals[3], vals[2]};
      `CHK(serial_number_out, ser[27:0])
      `CHK(lot_index_out, ser[13:0])
      `CHK(lot_number_out, {ser[29:28], ser[26:14]})
      `CHK({supplier_out, subcon_out}, ser[31:30])
      `CHK(vendor_type_out, ser[31:28])
      foreach (cfg_rows[r])
      begin
         prog(3'h1, cfg_rows[r][16:9], 1'b1);
         rd(`DIR_ADDR_CONFIG, cfg_rows[r][16:9], 1'b1);
         `CHK({silicon_revision_out, revision_valid_out, pressure_range_high_range_out, accel_fit_out,
               accel_extended_cal_out}, cfg_rows[r][8:0])
      end
      // a bus write must be flagged and leave the byte as it was
      bus_addr_in = `DIR_ADDR_SERIAL0;
      bus_wr_in = 1'b1;
      tick();
      bus_wr_in = 1'b0;
      `CHK(bus_wr_ignored_out, 1'b1)
      tick();
      rd(`DIR_ADDR_SERIAL0, vals[2], 1'b1);
      prog(3'h6, 8'hFF, 1'b1);
      rd(`DIR_ADDR_FW_DESC, vals[0], 1'b1);
      prog(3'h5, 8'h37, 1'b0);
      rd(`DIR_ADDR_SERIAL_VEND, {`DIR_VENDOR_DEFAULT, 4'h7}, 1'b1);
      `CHK(vendor_type_out, `DIR_VENDOR_DEFAULT)
      // restore every saved byte, as whoever erased the flash must
      for (int i = 0; i < 6; i++) prog(3'(i), vals[i], 1'b1);
      for (int i = 0; i < 6; i++) rd(addrs[i], vals[i], 1'b1);
      // cells are non-volatile, so a reset in mid-run keeps them
      sys_rst_in = 1'b1;
      tick();
      tick();
      `CHK(firmware_descriptor_out, 8'h00)
      sys_rst_in = 1'b0;
      tick();
      rd(`DIR_ADDR_FW_DESC, vals[0], 1'b1);
      // a low clock enable takes neither a read nor a programming write
      clk_en_in = 1'b0;
      bus_addr_in = `DIR_ADDR_FW_DESC;
      bus_rd_in = 1'b1;
      prog_we_in = 1'b1;
      prog_index_in = 3'h0;
      prog_data_in = 8'h00;
      tick();
      `CHK(bus_hit_out, 1'b0)
      bus_rd_in = 1'b0;
      prog_we_in = 1'b0;
      clk_en_in = 1'b1;
      tick();
      rd(`DIR_ADDR_FW_DESC, vals[0], 1'b1);
      tally_and_finish();
   end
endmodule // dir_identity_record_bench
`default_nettype wire
